// file: core/usp_pkg.sv
// Constants and carrier types for the speaker audio output path
package usp_pkg;
   // Register offsets on the firmware register port
   localparam logic [7:0] OFF_VOLUME   = 8'h1D;
   localparam logic [7:0] OFF_BANK_CTL = 8'h27;
   localparam logic [7:0] OFF_EP0_PORT = 8'h28;
   localparam logic [7:0] OFF_CLAMP_LO = 8'h2D;
   localparam logic [7:0] OFF_CLAMP_HI = 8'h2E;
   localparam logic [7:0] OFF_LOAD_CTL = 8'h2F;
   localparam int         EP_COUNT     = 3;

   // Field positions
   localparam int VOL_MUTE_N_BIT  = 7;
   localparam int LOAD_STROBE_BIT = 3;
   localparam int BANK_START_BIT  = 0;
   localparam int BANK_DONE_BIT   = 1;
   localparam int BANK_LAYOUT_BIT = 2;

   // Reset values
   localparam logic [7:0]  VOLUME_RESET   = 8'h00;
   localparam logic [7:0]  CLAMP_LO_RESET = 8'h00;
   localparam logic [7:0]  CLAMP_HI_RESET = 8'hFF;
   localparam logic [15:0] DAC_MIDSCALE   = 16'h8000;
   localparam logic [3:0]  DIRECT_WRITE_NIBBLE = 4'h5;

   // Gain, in signed half-dB steps
   localparam logic signed [7:0] GAIN_MAX_CODE  = 8'sh0C;
   localparam logic signed [7:0] GAIN_FINE_LOW  = -8'sh18;
   localparam logic signed [7:0] GAIN_MIN_CODE  = -8'sh2C;
   localparam logic signed [7:0] GAIN_MIN_HALF  = -8'sh40;

   // Speaker bank geometry
   localparam int BANK_BYTES  = 128;
   localparam int BANK_COUNT  = 4;
   localparam int BANK_TOTAL  = BANK_BYTES * BANK_COUNT;
   localparam int SPLIT_SAMPLES = BANK_TOTAL / 2;

   typedef struct packed {
      logic [15:0] left;
      logic [15:0] right;
   } usp_frame_t;

   typedef struct packed {
      logic [15:0] code;
      logic        load;
   } usp_dac_t;
endpackage : usp_pkg

// file: core/usp_audio_path.sv
// Speaker audio output path: volume, bank fill, endpoint ports, clamp and direct converter load
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module usp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   // Full and empty are told apart by the extra pointer bit

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("usp_fifo depth must be a power of two, at least 2");
   end

   // No reset on storage: words are only read behind out_valid
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign in_ready  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(push);
         rd_ptr <= rd_ptr + (AW+1)'(pop);
      end
   end
endmodule : usp_fifo

////////////////////////////////////////////////////////////////////////////////
module usp_audio_path #(
   parameter int FIFO_DEPTH = 32
) (
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [7:0]        reg_rdata,
   input  wire logic [3:0]        watchdog_setup_nibble,
   input  wire logic [2:0]        endpoint_enable,
   input  wire usp_pkg::usp_frame_t iso_frame,
   input  wire logic              iso_valid,
   output logic                   iso_ready,
   input  wire logic              dac_sample_req,
   output usp_pkg::usp_dac_t      dac_out,
   output logic signed [7:0]      gain_half_db,
   output logic                   speaker_mute,
   input  wire logic [8:0]        bank_raddr,
   output logic      [7:0]        bank_rdata
);
   import usp_pkg::*;

   if (FIFO_DEPTH < 2) begin : g_bad_param
      $error("usp_audio_path needs a FIFO of at least 2 words");
   end

   // Port index is two bits wide, so at most four endpoint ports fit
   if (EP_COUNT < 1 || EP_COUNT > 4) begin : g_bad_ep_count
      $error("usp_audio_path serves one to four endpoint ports");
   end

   // Bank address and fill counter are nine bits wide
   if (BANK_TOTAL != 512 || SPLIT_SAMPLES * 2 != BANK_TOTAL) begin : g_bad_banks
      $error("usp_audio_path bank geometry must total 512 bytes");
   end

   // Bank byte from a 16-bit two's complement sample
   // truncate to byte
   function automatic logic [7:0] to_bank_byte(input logic [15:0] s);
      return {s[15], s[13:7]};
   endfunction : to_bank_byte

   // Unsigned offset code with the host limit applied
   // clamp to limit
   function automatic logic [15:0] clamp_code(input logic [15:0] s, input logic [15:0] lim);
      logic [15:0] u;
      u = s ^ DAC_MIDSCALE;
      return (u > lim) ? lim : u;
   endfunction : clamp_code

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  volume_mute_reg;
   logic [7:0]  converter_clamp_lo_byte;
   logic [7:0]  converter_clamp_hi_byte;
   logic        converter_load_strobe;
   logic        strobe_prev;
   logic        bank_fill_start;
   logic        bank_fill_done;
   logic        bank_layout_select;
   // Port storage has no reset; content is undefined until written
   logic [7:0]  endpoint_access_port [EP_COUNT];
   logic [8:0]  fill_cnt;
   // Bank storage has no reset; it is meant to be read after a completed fill
   logic [7:0]  bank_ram [BANK_TOTAL];

   wire sel_volume = reg_addr == OFF_VOLUME;
   wire sel_bank   = reg_addr == OFF_BANK_CTL;
   wire sel_lo     = reg_addr == OFF_CLAMP_LO;
   wire sel_hi     = reg_addr == OFF_CLAMP_HI;
   wire sel_load   = reg_addr == OFF_LOAD_CTL;
   wire [7:0] ep_off  = reg_addr - OFF_EP0_PORT;
   wire       sel_ep  = (reg_addr >= OFF_EP0_PORT) && (ep_off < 8'(EP_COUNT));
   wire [1:0] ep_idx  = ep_off[1:0];
   wire       ep_live = sel_ep && endpoint_enable[ep_idx];

   ////////////////////////////////////////////////////////////////////////////
   // Sample stream
   usp_frame_t head;
   logic       head_valid;
   wire        pop = head_valid && dac_sample_req;

   usp_fifo #(
      .WIDTH ($bits(usp_frame_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rstn      (rstn),
      .in_data   (iso_frame),
      .in_valid  (iso_valid),
      .in_ready  (iso_ready),
      .out_data  (head),
      .out_valid (head_valid),
      .out_ready (dac_sample_req)
   );

   // Sum taken at 17 bits so two full-scale samples cannot overflow
   wire [16:0] lr_sum  = {head.left[15], head.left} + {head.right[15], head.right};
   wire [15:0] lr_avg  = lr_sum[16:1];
   // High byte resets to FF and low byte to 00, so the clamp only caps codes above FF00 until firmware narrows it
   wire [15:0] limit   = {converter_clamp_hi_byte, converter_clamp_lo_byte};

   // Layout should stay put during a fill: the end point follows it live
   // layout picks the fill end
   wire [8:0] fill_last = bank_layout_select ? 9'(SPLIT_SAMPLES - 1) : 9'(BANK_TOTAL - 1);
   wire       fill_step = bank_fill_start && pop;
   wire       fill_end  = fill_step && (fill_cnt == fill_last);

   ////////////////////////////////////////////////////////////////////////////
   // Gain decode
   // Code read as signed seven bits; sign extension keeps the compares signed
   wire logic signed [7:0] gcode = 8'(signed'(volume_mute_reg[6:0]));

   // Gain in half-dB units from the signed gain code
   // saturate undefined codes
   function automatic logic signed [7:0] gain_of(input logic signed [7:0] g);
      logic signed [7:0] coarse;
      // Each code step below -12 dB is worth two half-dB units
      coarse = 8'(g + g - GAIN_FINE_LOW);
      if (g > GAIN_MAX_CODE) begin
         return GAIN_MAX_CODE;
      end else if (g < GAIN_MIN_CODE) begin
         return GAIN_MIN_HALF;
      end else if (g >= GAIN_FINE_LOW) begin
         return g;
      end
      return coarse;
   endfunction : gain_of

   assign gain_half_db = gain_of(gcode);
   assign speaker_mute = !volume_mute_reg[VOL_MUTE_N_BIT];

   // One pulse per fall, however long the strobe then stays low
   // falling edge compare
   wire strobe_fall = strobe_prev && !converter_load_strobe;
   wire direct_mode = watchdog_setup_nibble == DIRECT_WRITE_NIBBLE;

   ////////////////////////////////////////////////////////////////////////////
   // Register writes
   always_ff @(posedge clock) begin
      if (!rstn) begin
         volume_mute_reg         <= VOLUME_RESET;
         converter_clamp_lo_byte <= CLAMP_LO_RESET;
         converter_clamp_hi_byte <= CLAMP_HI_RESET;
         converter_load_strobe   <= 1'b0;
         strobe_prev             <= 1'b0;
         bank_layout_select      <= 1'b0;
      end else begin
         // History runs every cycle so a fall is seen without further writes
         strobe_prev <= converter_load_strobe;
         if (reg_write) begin
            if (sel_volume) begin
               volume_mute_reg <= reg_wdata;
            end
            if (sel_lo) begin
               converter_clamp_lo_byte <= reg_wdata;
            end
            if (sel_hi) begin
               converter_clamp_hi_byte <= reg_wdata;
            end
            if (sel_load) begin
               converter_load_strobe <= reg_wdata[LOAD_STROBE_BIT];
            end
            if (sel_bank) begin
               bank_layout_select <= reg_wdata[BANK_LAYOUT_BIT];
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reg_write && ep_live) begin
         endpoint_access_port[ep_idx] <= reg_wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bank fill control
   always_ff @(posedge clock) begin
      if (!rstn) begin
         bank_fill_start <= 1'b0;
         bank_fill_done  <= 1'b0;
         fill_cnt        <= '0;
      end else begin
         if (reg_write && sel_bank && reg_wdata[BANK_START_BIT] && !bank_fill_start) begin
            bank_fill_start <= 1'b1;
            fill_cnt        <= '0;
         end else if (fill_end) begin
            bank_fill_start <= 1'b0;
         end else if (fill_step) begin
            fill_cnt <= fill_cnt + 9'd1;
         end
         if (fill_end) begin
            bank_fill_done <= 1'b1;
         end else if (reg_write && sel_bank) begin
            bank_fill_done <= reg_wdata[BANK_DONE_BIT];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (fill_step) begin
         if (bank_layout_select) begin
            bank_ram[fill_cnt]                       <= to_bank_byte(head.left);
            bank_ram[9'(fill_cnt + 9'(SPLIT_SAMPLES))] <= to_bank_byte(head.right);
         end else begin
            bank_ram[fill_cnt] <= to_bank_byte(lr_avg);
         end
      end
   end

   always_ff @(posedge clock) begin
      bank_rdata <= bank_ram[bank_raddr];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Converter output
   // A direct load and a pop in one cycle: the direct load wins and that
   // sample never reaches the converter, though the banks still store it while a fill is running
   always_ff @(posedge clock) begin
      if (!rstn) begin
         dac_out.code <= DAC_MIDSCALE;
         dac_out.load <= 1'b0;
      end else begin
         dac_out.load <= 1'b0;
         if (strobe_fall && direct_mode) begin
            dac_out.code <= limit;
            dac_out.load <= 1'b1;
         end else if (pop) begin
            dac_out.code <= speaker_mute ? DAC_MIDSCALE : clamp_code(lr_avg, limit);
            dac_out.load <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register reads, answered one cycle after the read strobe
   // Unmapped addresses fall through to the port path, which reads zero
   wire [7:0] ep_read = ep_live ? endpoint_access_port[ep_idx] : 8'h00;
   wire [7:0] bank_ctl = {5'h00, bank_layout_select, bank_fill_done, bank_fill_start};
   wire [7:0] read_mux = sel_volume ? volume_mute_reg :
                         sel_lo     ? converter_clamp_lo_byte :
                         sel_hi     ? converter_clamp_hi_byte :
                         sel_load   ? {4'h0, converter_load_strobe, 3'h0} :
                         sel_bank   ? bank_ctl :
                         ep_read;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         reg_rdata <= read_mux;
      end
   end
endmodule : usp_audio_path

// file: verification/usp_host_model.sv
// Host isochronous stream source: numbered stereo frames
`timescale 1ns/100ps
module usp_host_model (
   input  wire logic          clock,
   input  wire logic          rstn,
   input  wire logic          en,
   input  wire logic          iso_ready,
   output usp_pkg::usp_frame_t iso_frame,
   output logic               iso_valid
);
   import usp_pkg::*;
   logic [9:0]  k;
   usp_frame_t  f;
   // frames offered once filling is armed
   always_ff @(posedge clock) begin
      if (!rstn)
         k <= '0;
      else if (iso_valid && iso_ready)
         k <= k + 10'h001;
   end
   assign iso_valid = en && (k < 10'h300);
   assign f = {k[7:0], 8'h80, k[7:0], 8'h00};
   // Idle bus shows the inverse so stale data never passes as valid
   assign iso_frame = iso_valid ? f : ~f;
endmodule : usp_host_model

// file: verification/usp_audio_path_asserts.sv
// Port checks for the speaker audio output path
`timescale 1ns/100ps
module usp_audio_path_chk #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic              clock,
   input wire logic              rstn,
   input wire logic        [7:0] reg_addr,
   input wire logic        [7:0] reg_wdata,
   input wire logic              reg_write,
   input wire logic              reg_read,
   input wire logic        [7:0] reg_rdata,
   input wire logic        [3:0] watchdog_setup_nibble,
   input wire logic        [2:0] endpoint_enable,
   input wire logic              dac_sample_req,
   input wire usp_pkg::usp_dac_t dac_out,
   input wire logic signed [7:0] gain_half_db,
   input wire logic              speaker_mute
);
   import usp_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   wire              vw = reg_write && reg_addr == OFF_VOLUME;
   wire signed [7:0] vc = $signed(reg_wdata[6:0]);
   wire              ls = reg_write && reg_addr == OFF_LOAD_CTL && reg_wdata[LOAD_STROBE_BIT];
   wire              lc = reg_write && reg_addr == OFF_LOAD_CTL && !reg_wdata[LOAD_STROBE_BIT];
   wire              dw = watchdog_setup_nibble == DIRECT_WRITE_NIBBLE;
   property p_rst;
      $rose(rstn) |-> gain_half_db == 8'sh00 && speaker_mute;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state wrong");
   property p_mute;
      vw |=> speaker_mute == !$past(reg_wdata[VOL_MUTE_N_BIT]);
   endproperty
   a_mute: assert property (p_mute) else $error("mute wrong");
   property p_fine;
      vw && vc <= GAIN_MAX_CODE && vc >= GAIN_FINE_LOW |=> gain_half_db == $past(vc);
   endproperty
   a_fine: assert property (p_fine) else $error("fine gain wrong");
   property p_coarse;
      vw && vc < GAIN_FINE_LOW && vc >= GAIN_MIN_CODE |=> gain_half_db == 2 * $past(vc) + 24;
   endproperty
   a_coarse: assert property (p_coarse) else $error("coarse gain wrong");
   property p_sat;
      vw && (vc > GAIN_MAX_CODE || vc < GAIN_MIN_CODE)
         |=> gain_half_db == ($past(vc) > 0 ? GAIN_MAX_CODE : GAIN_MIN_HALF);
   endproperty
   a_sat: assert property (p_sat) else $error("gain not saturated");
   property p_direct;
      ls ##[1:6] (lc && dw) |-> ##2 dac_out.load;
   endproperty
   a_direct: assert property (p_direct) else $error("no direct load");
   property p_nodirect;
      ls ##[1:6] (lc && !dw) |-> ##2 (!dac_out.load || $past(dac_sample_req));
   endproperty
   a_nodirect: assert property (p_nodirect) else $error("stray load");
   property p_mutec;
      dac_sample_req && speaker_mute && !lc ##1 dac_out.load |-> dac_out.code == DAC_MIDSCALE;
   endproperty
   a_mutec: assert property (p_mutec) else $error("muted code wrong");
   property p_ldrd;
      reg_read && reg_addr == OFF_LOAD_CTL |=> (reg_rdata & 8'hF7) == 8'h00;
   endproperty
   a_ldrd: assert property (p_ldrd) else $error("load reg bits");
   property p_ep;
      reg_read && reg_addr >= OFF_EP0_PORT && reg_addr <= 8'h2A && !endpoint_enable[reg_addr[1:0]]
         |=> reg_rdata == 8'h00;
   endproperty
   a_ep: assert property (p_ep) else $error("disabled port read");
endmodule : usp_audio_path_chk
bind usp_audio_path usp_audio_path_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
   .clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
   .watchdog_setup_nibble, .endpoint_enable, .dac_sample_req, .dac_out,
   .gain_half_db, .speaker_mute
);

// file: verification/usp_audio_path_bench.sv
// Self-checking bench for the speaker audio output path
`timescale 1ns/100ps
module usp_audio_path_bench;
   import usp_pkg::*;
   logic              clock, rstn, reg_write, reg_read, iso_valid, iso_ready;
   logic              dac_sample_req, speaker_mute, host_en;
   logic        [7:0] reg_addr, reg_wdata, reg_rdata, bank_rdata;
   logic        [8:0] bank_raddr;
   logic        [3:0] watchdog_setup_nibble;
   logic        [2:0] endpoint_enable;
   logic signed [7:0] gain_half_db;
   usp_frame_t        iso_frame;
   usp_dac_t          dac_out;
   int                err_count = 0;
   int                cmp_count = 0;
   localparam logic        [7:0] VC [7] = '{8'h8C, 8'hE8, 8'hD4, 8'h7F, 8'h20, 8'hD0, 8'hDE};
   localparam logic signed [7:0] GX [7] = '{8'sh0C, -8'sh18, -8'sh40, -8'sh01, 8'sh0C, -8'sh40, -8'sh2C};
   usp_audio_path #(.FIFO_DEPTH(32)) dut (
      .clock, .rstn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
      .watchdog_setup_nibble, .endpoint_enable, .iso_frame, .iso_valid, .iso_ready,
      .dac_sample_req, .dac_out, .gain_half_db, .speaker_mute, .bank_raddr, .bank_rdata
   );
   usp_host_model host (.clock, .rstn, .en(host_en), .iso_ready, .iso_frame, .iso_valid);
   ////////////////////////////////////////
   task automatic results;
      $display("Compares %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      @(negedge clock);
      chk({8'h00, reg_rdata}, {8'h00, e});
   endtask : rd
   // clamp pair, then strobe set and clear
   task automatic dload(input logic [7:0] lo, input logic [7:0] hi);
      wr(OFF_CLAMP_LO, lo);
      wr(OFF_CLAMP_HI, hi);
      wr(OFF_LOAD_CTL, 8'h08);
      wr(OFF_LOAD_CTL, 8'h00);
   endtask : dload
   task automatic pop;
      @(posedge clock);
      dac_sample_req <= 1'b1;
      @(posedge clock);
      dac_sample_req <= 1'b0;
   endtask : pop
   task automatic waitld(input logic [15:0] e);
      int n = 0;
      @(negedge clock);
      while (dac_out.load !== 1'b1 && n < 8) begin
         @(negedge clock);
         n++;
      end
      chk({15'h0000, dac_out.load}, 16'h0001);
      chk(dac_out.code, e);
   endtask : waitld
   task automatic fill(input int cnt, input logic m);
      logic [15:0] e;
      for (int k = 0; k < cnt; k++) begin
         e = {~k[7], k[6:0], 8'h40};
         if (e > 16'hA000)
            e = 16'hA000;
         pop();
         waitld(m ? DAC_MIDSCALE : e);
      end
   endtask : fill
   task automatic bank(input int a, input logic [15:0] s);
      @(posedge clock);
      bank_raddr <= 9'(a);
      @(posedge clock);
      @(negedge clock);
      chk({8'h00, bank_rdata}, {8'h00, s[15], s[13:7]});
   endtask : bank
   ////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      results();
   end
   initial begin
      {rstn, reg_write, reg_read, dac_sample_req, host_en} = '0;
      {reg_addr, reg_wdata, watchdog_setup_nibble, endpoint_enable, bank_raddr} = '0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      rd(OFF_VOLUME, VOLUME_RESET);
      chk(speaker_mute, 1'b1);
      for (int i = 0; i < 7; i++) begin
         wr(OFF_VOLUME, VC[i]);
         rd(OFF_VOLUME, VC[i]);
         chk(16'(gain_half_db), 16'(GX[i]));
         chk(speaker_mute, !VC[i][7]);
      end
      @(posedge clock);
      endpoint_enable <= 3'b001;
      wr(OFF_EP0_PORT, 8'hA5);
      rd(OFF_EP0_PORT, 8'hA5);
      wr(8'h29, 8'h5A);
      rd(8'h29, 8'h00);
      rd(8'h30, 8'h00);
      wr(OFF_LOAD_CTL, 8'hFF);
      rd(OFF_LOAD_CTL, 8'h08);
      @(posedge clock);
      watchdog_setup_nibble <= DIRECT_WRITE_NIBBLE;
      dload(8'h34, 8'h12);
      waitld(16'h1234);
      dload(8'h00, 8'h80);
      waitld(DAC_MIDSCALE);
      @(posedge clock);
      watchdog_setup_nibble <= 4'h0;
      dload(8'h00, 8'hA0);
      repeat (4) @(negedge clock);
      chk(dac_out.code, DAC_MIDSCALE);
      wr(OFF_VOLUME, 8'h80);
      wr(OFF_BANK_CTL, 8'h01);
      host_en <= 1'b1;
      repeat (40) @(posedge clock);
      chk(iso_ready, 1'b0);
      fill(512, 1'b0);
      rd(OFF_BANK_CTL, 8'h02);
      for (int i = 0; i < 512; i += 127)
         bank(i, {i[7:0], 8'h40});
      wr(OFF_VOLUME, 8'h00);
      wr(OFF_BANK_CTL, 8'h05);
      fill(256, 1'b1);
      rd(OFF_BANK_CTL, 8'h06);
      for (int i = 0; i < 256; i += 85) begin
         bank(i, {i[7:0], 8'h80});
         bank(i + 256, {i[7:0], 8'h00});
      end
      pop();
      @(negedge clock);
      chk(dac_out.load, 1'b0);
      results();
   end
endmodule : usp_audio_path_bench
